// [logic/dssc_pkg.sv]
// Shared constants and types for the dual synthesizer serial control block.
package dssc_pkg;

    // Serial word layout: data field above a two-bit address field.
    localparam int SR_W = 22;
    localparam int DATA_W = 20;
    localparam int ADDR_W = 2;

    // Control register addresses.
    localparam logic [1:0] ADDR_AUX_REF = 2'h0;
    localparam logic [1:0] ADDR_AUX_FB = 2'h1;
    localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
    localparam logic [1:0] ADDR_MAIN_FB = 2'h3;
    localparam logic [19:0] CTL_RESET = 20'h00000;

    // Field positions in shift register coordinates.
    localparam int REF_DIV_LSB = 2;
    localparam int REF_DIV_MSB = 16;
    localparam int REF_POL_BIT = 17;
    localparam int REF_CUR_BIT = 18;
    localparam int REF_FLOAT_BIT = 19;
    localparam int REF_SEL_LO_BIT = 20;
    localparam int REF_SEL_HI_BIT = 21;
    localparam int FB_SW_LSB = 2;
    localparam int FB_SW_MSB = 6;
    localparam int FB_BIN_LSB = 7;
    localparam int FB_BIN_MSB = 19;
    localparam int FB_PRE_BIT = 20;
    localparam int FB_PWDN_BIT = 21;

    // Loop indices and synchroniser bit positions.
    localparam int LOOP_AUX = 0;
    localparam int LOOP_MAIN = 1;
    localparam int SY_LATCH = 0;
    localparam int SY_BUSY = 1;
    localparam int SY_MON = 3;
    localparam int SY_W = 7;

    // Divider settling time after a loop is reactivated.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 1000;
    localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Operating mode, coded as {float bit, powerdown bit}.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SYNC_PD = 2'h1;
    localparam logic [1:0] MODE_FLOAT = 2'h2;
    localparam logic [1:0] MODE_ASYNC_PD = 2'h3;

    typedef enum logic [3:0] {
        FSEL_LOW = 4'h0,
        FSEL_AUX_REF = 4'h1,
        FSEL_AUX_FB = 4'h2,
        FSEL_MAIN_REF = 4'h3,
        FSEL_MAIN_FB = 4'h4,
        FSEL_RAPID = 4'h5,
        FSEL_RST_AUX = 4'h6,
        FSEL_RST_MAIN = 4'h7,
        FSEL_RST_ALL = 4'h8
    } dssc_fsel_e;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'b000,
        PWR_SYNC_ARM = 3'b001,
        PWR_SYNC_END = 3'b010,
        PWR_DOWN = 3'b011,
        PWR_WAKE = 3'b100
    } dssc_pwr_e;

    typedef struct packed {
        logic [14:0] reference_divide_value;
        logic detector_polarity;
        logic pump_current_sel;
        logic [12:0] binary_count_value;
        logic [4:0] swallow_count_value;
        logic prescaler_sel;
        logic power_off;
        logic pump_float;
        logic input_float;
        logic div_hold;
    } dssc_loop_s;

    typedef struct packed {
        logic [21:0] shreg;
    } dssc_ser_s;

    typedef struct packed {
        logic [SY_W-1:0] meta;
        logic [SY_W-1:0] sync;
        logic latch_prev;
        logic [3:0][19:0] ctl;
        dssc_pwr_e [1:0] pwr;
        logic [1:0][7:0] settle;
        dssc_loop_s [1:0] loop;
        logic mfo;
        logic rapid_lvl;
        logic rapid_oe;
        logic osc_off;
    } dssc_sys_s;

endpackage : dssc_pkg

// [logic/dssc_serial_control.sv]
// Serial control port, control registers and loop power sequencing.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RQ1] Shift register: 20 data bits, 2 address
// [RQ2] One data bit captured per serial rising edge
// [RQ3] Host sends MSB first, address last
// [RQ4] Strobe rise copies word into addressed register
// [RQ5] Address 0..3: auxR, auxN, mainR, mainN
// [RQ6] Reference register: divider, polarity, current, float
// [RQ7] Reference bits 21,20 carry selector bits
// [RQ8] Feedback register: powerdown, prescaler, binary, swallow
// [RQ9] Rapid acquisition closes open-drain ground switch
// [RQ10] Host raises pump current during rapid acquisition
// [RQ11] Aux counter reset holds aux dividers
// [RQ12] Main counter reset holds main dividers
// [RQ13] All-counters reset holds every divider
// [RQ14] Normal selector releases dividers together
// [RQ15] Selector routes any divider to output
// [RQ16] Each loop has independent power control
// [RQ17] Powerdown disables loop and floats its pins
// [RQ18] Powered-down loop keeps its dividers held
// [RQ19] Both down: oscillator buffer off, pulled high
// [RQ20] Reactivation holds dividers for settling delay
// [RQ21] Serial port works during any powerdown
// [RQ22] Synchronous powerdown waits for pump pulse end
// [RQ23] Asynchronous powerdown enters immediately
// [RQ24] Float and powerdown bits select mode
// [RQ25] Multi-function output low during powerdown
// [RQ26] Only the last 22 bits are kept
module dssc_serial_control
    import dssc_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial link from the host
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    // Status from the analog loops
    input wire logic aux_pump_busy,
    input wire logic main_pump_busy,
    input wire logic aux_ref_div_out,
    input wire logic aux_fb_div_out,
    input wire logic main_ref_div_out,
    input wire logic main_fb_div_out,
    // Per-loop controls
    output var dssc_loop_s aux_ctl,
    output var dssc_loop_s main_ctl,
    // Shared controls and pins
    output logic osc_buffer_off,
    output logic reference_pullup_en,
    output logic multi_function_out,
    output logic rapid_switch_o,
    output logic rapid_switch_oe
);

    dssc_ser_s ser_q;
    dssc_ser_s ser_d;
    dssc_sys_s st_q;
    dssc_sys_s st_d;
    logic [SY_W-1:0] pin_in;
    logic [1:0] word_addr;
    logic [19:0] word_data;
    logic [3:0] sel_bits;
    logic [1:0] aux_mode;
    logic [1:0] main_mode;

    assign pin_in = {main_fb_div_out, main_ref_div_out, aux_fb_div_out, aux_ref_div_out,
                     main_pump_busy, aux_pump_busy, latch_strobe};

    // The serial port has no power gating at all, so it keeps shifting in
    // powerdown. Extra bits simply fall off the top of the register.
    always_comb begin
        ser_d = ser_q;
        ser_d.shreg = {ser_q.shreg[SR_W-2:0], ser_data}; // [RQ1] [RQ2] [RQ26] [RQ21]
    end

    always_ff @(posedge ser_clk or posedge rst) begin
        if (rst) begin
            ser_q <= '0;
        end else begin
            ser_q <= ser_d;
        end
    end

    // The word is read across domains only after the synchronised strobe
    // rises; the host keeps the serial clock still while the strobe is high.
    assign word_addr = ser_q.shreg[ADDR_W-1:0];
    assign word_data = ser_q.shreg[SR_W-1:ADDR_W];

    // Selector bits 0 and 2 sit in the aux reference register, 1 and 3 in main.
    assign sel_bits = {st_q.ctl[ADDR_MAIN_REF][REF_SEL_LO_BIT-ADDR_W],
                       st_q.ctl[ADDR_AUX_REF][REF_SEL_LO_BIT-ADDR_W],
                       st_q.ctl[ADDR_MAIN_REF][REF_SEL_HI_BIT-ADDR_W],
                       st_q.ctl[ADDR_AUX_REF][REF_SEL_HI_BIT-ADDR_W]}; // [RQ7]

    assign aux_mode = {st_q.ctl[ADDR_AUX_REF][REF_FLOAT_BIT-ADDR_W],
                       st_q.ctl[ADDR_AUX_FB][FB_PWDN_BIT-ADDR_W]};
    assign main_mode = {st_q.ctl[ADDR_MAIN_REF][REF_FLOAT_BIT-ADDR_W],
                        st_q.ctl[ADDR_MAIN_FB][FB_PWDN_BIT-ADDR_W]};

    always_comb begin
        logic [1:0] mode;
        logic busy;
        logic rst_hold;
        logic [19:0] refr;
        logic [19:0] fbr;
        logic any_down;
        dssc_fsel_e sel;
        mode = MODE_NORMAL;
        busy = 1'b0;
        rst_hold = 1'b0;
        refr = '0;
        fbr = '0;
        any_down = 1'b0;
        sel = dssc_fsel_e'(sel_bits);
        st_d = st_q;

        // Only the second stage feeds any logic.
        st_d.meta = pin_in;
        st_d.sync = st_q.meta;
        st_d.latch_prev = st_q.sync[SY_LATCH];

        if (st_q.sync[SY_LATCH] && !st_q.latch_prev) begin
            st_d.ctl[word_addr] = word_data; // [RQ4] [RQ5] [RQ21]
        end

        for (int i = 0; i < 2; i++) begin
            refr = st_q.ctl[2*i];
            fbr = st_q.ctl[2*i+1];
            mode = {refr[REF_FLOAT_BIT-ADDR_W], fbr[FB_PWDN_BIT-ADDR_W]}; // [RQ24] [RQ16]
            busy = st_q.sync[SY_BUSY+i];
            case (st_q.pwr[i])
                PWR_ACTIVE: begin
                    if (mode == MODE_ASYNC_PD) begin
                        st_d.pwr[i] = PWR_DOWN; // [RQ23]
                    end else if (mode == MODE_SYNC_PD) begin
                        st_d.pwr[i] = busy ? PWR_SYNC_END : PWR_SYNC_ARM; // [RQ22]
                    end
                end
                PWR_SYNC_ARM: begin
                    if (!mode[0]) begin
                        st_d.pwr[i] = PWR_ACTIVE;
                    end else if (mode == MODE_ASYNC_PD) begin
                        st_d.pwr[i] = PWR_DOWN;
                    end else if (busy) begin
                        st_d.pwr[i] = PWR_SYNC_END; // [RQ22]
                    end
                end
                PWR_SYNC_END: begin
                    if (!mode[0]) begin
                        st_d.pwr[i] = PWR_ACTIVE;
                    end else if (mode == MODE_ASYNC_PD || !busy) begin
                        st_d.pwr[i] = PWR_DOWN; // [RQ22]
                    end
                end
                PWR_DOWN: begin
                    if (!mode[0]) begin
                        st_d.pwr[i] = PWR_WAKE;
                        st_d.settle[i] = SETTLE_CYC - 8'h01; // [RQ20]
                    end
                end
                PWR_WAKE: begin
                    if (mode[0]) begin
                        st_d.pwr[i] = PWR_DOWN;
                    end else if (st_q.settle[i] == 8'h00) begin
                        st_d.pwr[i] = PWR_ACTIVE; // [RQ20] [RQ14]
                    end else begin
                        st_d.settle[i] = st_q.settle[i] - 8'h01;
                    end
                end
                default: begin
                    st_d.pwr[i] = PWR_DOWN;
                end
            endcase

            if (i == LOOP_AUX) begin
                rst_hold = (sel == FSEL_RST_AUX) || (sel == FSEL_RST_ALL); // [RQ11] [RQ13]
            end else begin
                rst_hold = (sel == FSEL_RST_MAIN) || (sel == FSEL_RST_ALL); // [RQ12] [RQ13]
            end

            st_d.loop[i].reference_divide_value = refr[REF_DIV_MSB-ADDR_W:REF_DIV_LSB-ADDR_W]; // [RQ6]
            st_d.loop[i].detector_polarity = refr[REF_POL_BIT-ADDR_W]; // [RQ6]
            st_d.loop[i].pump_current_sel = refr[REF_CUR_BIT-ADDR_W]; // [RQ6]
            st_d.loop[i].binary_count_value = fbr[FB_BIN_MSB-ADDR_W:FB_BIN_LSB-ADDR_W]; // [RQ8]
            st_d.loop[i].swallow_count_value = fbr[FB_SW_MSB-ADDR_W:FB_SW_LSB-ADDR_W]; // [RQ8]
            st_d.loop[i].prescaler_sel = fbr[FB_PRE_BIT-ADDR_W]; // [RQ8]
            st_d.loop[i].power_off = (st_d.pwr[i] == PWR_DOWN); // [RQ17]
            st_d.loop[i].input_float = (st_d.pwr[i] == PWR_DOWN); // [RQ17]
            st_d.loop[i].pump_float = (st_d.pwr[i] == PWR_DOWN) || refr[REF_FLOAT_BIT-ADDR_W]; // [RQ17] [RQ24]
            // One hold per loop drives both dividers, so they restart together.
            st_d.loop[i].div_hold = (st_d.pwr[i] == PWR_DOWN) || (st_d.pwr[i] == PWR_WAKE)
                                    || rst_hold; // [RQ18] [RQ20] [RQ14]
            any_down = any_down || (st_d.pwr[i] == PWR_DOWN);
        end

        st_d.osc_off = (st_d.pwr[LOOP_AUX] == PWR_DOWN) && (st_d.pwr[LOOP_MAIN] == PWR_DOWN); // [RQ19]

        // The rapid-acquisition switch only ever pulls to ground.
        st_d.rapid_lvl = 1'b0;
        st_d.rapid_oe = (sel == FSEL_RAPID) && (st_d.pwr[LOOP_MAIN] != PWR_DOWN); // [RQ9]

        case (sel)
            FSEL_AUX_REF: st_d.mfo = st_q.sync[SY_MON]; // [RQ15]
            FSEL_AUX_FB: st_d.mfo = st_q.sync[SY_MON+1]; // [RQ15]
            FSEL_MAIN_REF: st_d.mfo = st_q.sync[SY_MON+2]; // [RQ15]
            FSEL_MAIN_FB: st_d.mfo = st_q.sync[SY_MON+3]; // [RQ15]
            default: st_d.mfo = 1'b0;
        endcase
        if (any_down) begin
            st_d.mfo = 1'b0; // [RQ25]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign aux_ctl = st_q.loop[LOOP_AUX];
    assign main_ctl = st_q.loop[LOOP_MAIN];
    assign osc_buffer_off = st_q.osc_off;
    assign reference_pullup_en = st_q.osc_off;
    assign multi_function_out = st_q.mfo;
    assign rapid_switch_o = st_q.rapid_lvl;
    assign rapid_switch_oe = st_q.rapid_oe;

    AST_SHIFT_IN: assert property (@(posedge ser_clk) disable iff (rst) // [RQ2]
        ##1 (ser_q.shreg[0] == $past(ser_data)
             && ser_q.shreg[SR_W-1:1] == $past(ser_q.shreg[SR_W-2:0])))
        else $error("Serial bit was not shifted into the word.");

    AST_LATCH_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
        (st_q.sync[SY_LATCH] && !st_q.latch_prev)
        |=> (st_q.ctl[$past(word_addr)] == $past(word_data)))
        else $error("Latched word did not reach the addressed register.");

    AST_ASYNC_PD: assert property (@(posedge clk_sys) disable iff (rst) // [RQ23]
        (st_q.pwr[LOOP_MAIN] == PWR_ACTIVE && main_mode == MODE_ASYNC_PD)
        |=> (st_q.pwr[LOOP_MAIN] == PWR_DOWN && main_ctl.power_off && main_ctl.pump_float))
        else $error("Asynchronous powerdown was not immediate.");

    AST_SYNC_WAIT: assert property (@(posedge clk_sys) disable iff (rst) // [RQ22]
        (st_q.pwr[LOOP_AUX] == PWR_ACTIVE && aux_mode == MODE_SYNC_PD
         && !st_q.sync[SY_BUSY+LOOP_AUX])
        |=> (st_q.pwr[LOOP_AUX] == PWR_SYNC_ARM && !aux_ctl.power_off))
        else $error("Synchronous powerdown did not wait for a pump pulse.");

    AST_DOWN_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RQ18]
        (st_q.pwr[LOOP_AUX] == PWR_DOWN) |-> (aux_ctl.div_hold && aux_ctl.input_float))
        else $error("Powered-down loop has dividers running.");

    AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (rst) // [RQ19]
        osc_buffer_off == (main_ctl.power_off && aux_ctl.power_off))
        else $error("Oscillator buffer state disagrees with loop power.");

    AST_WAKE_SETTLE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ20]
        ($past(st_q.pwr[LOOP_MAIN]) == PWR_DOWN && st_q.pwr[LOOP_MAIN] == PWR_WAKE
         && !main_mode[0])
        |-> (main_ctl.div_hold && !main_ctl.power_off)[*8])
        else $error("Dividers released before the settling delay.");

    AST_MULTI_FUNCTION_OUT_LOW: assert property (@(posedge clk_sys) disable iff (rst) // [RQ25]
        (main_ctl.power_off || aux_ctl.power_off) |-> !multi_function_out)
        else $error("Multi-function output not low in powerdown.");

    AST_RESET_ALL: assert property (@(posedge clk_sys) disable iff (rst) // [RQ13]
        (sel_bits == FSEL_RST_ALL) |=> (aux_ctl.div_hold && main_ctl.div_hold))
        else $error("All-counters reset did not hold every divider.");

    AST_RAPID: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
        (sel_bits == FSEL_RAPID && st_q.pwr[LOOP_MAIN] == PWR_ACTIVE
         && main_mode == MODE_NORMAL) |=> rapid_switch_oe && !rapid_switch_o)
        else $error("Rapid-acquisition switch not closed.");

    AST_FLOAT: assert property (@(posedge clk_sys) disable iff (rst) // [RQ24]
        (main_mode == MODE_FLOAT && st_q.pwr[LOOP_MAIN] == PWR_ACTIVE)
        |=> (main_ctl.pump_float && !main_ctl.power_off))
        else $error("Float mode did not float the pump alone.");

    AST_LATCH_ONLY: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
        !(st_q.sync[SY_LATCH] && !st_q.latch_prev) |=> (st_q.ctl == $past(st_q.ctl)))
        else $error("Control register changed without a strobe.");

    AST_ADDR_AUX_FB: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
        (st_q.sync[SY_LATCH] && !st_q.latch_prev && word_addr == ADDR_AUX_FB)
        |=> (st_q.ctl[ADDR_AUX_FB] == $past(word_data)
             && st_q.ctl[ADDR_MAIN_FB] == $past(st_q.ctl[ADDR_MAIN_FB])))
        else $error("Address did not select the aux feedback register alone.");

    // Both checks compare against the register one cycle back, because the
    // per-loop outputs are registered copies of the decoded fields.
    AST_REF_FIELDS: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
        aux_ctl.reference_divide_value
        == $past(st_q.ctl[ADDR_AUX_REF][REF_DIV_MSB-ADDR_W:REF_DIV_LSB-ADDR_W])
        && main_ctl.detector_polarity == $past(st_q.ctl[ADDR_MAIN_REF][REF_POL_BIT-ADDR_W])
        && main_ctl.pump_current_sel == $past(st_q.ctl[ADDR_MAIN_REF][REF_CUR_BIT-ADDR_W]))
        else $error("Reference register fields not decoded.");

    AST_FB_FIELDS: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
        main_ctl.binary_count_value
        == $past(st_q.ctl[ADDR_MAIN_FB][FB_BIN_MSB-ADDR_W:FB_BIN_LSB-ADDR_W])
        && aux_ctl.swallow_count_value
        == $past(st_q.ctl[ADDR_AUX_FB][FB_SW_MSB-ADDR_W:FB_SW_LSB-ADDR_W])
        && aux_ctl.prescaler_sel == $past(st_q.ctl[ADDR_AUX_FB][FB_PRE_BIT-ADDR_W]))
        else $error("Feedback register fields not decoded.");

    AST_RAPID_OPEN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
        (sel_bits != FSEL_RAPID) |=> (!rapid_switch_oe && !rapid_switch_o))
        else $error("Rapid-acquisition switch closed outside its mode.");

    AST_RESET_AUX: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
        (sel_bits == FSEL_RST_AUX) |=> aux_ctl.div_hold)
        else $error("Aux counter reset did not hold the aux dividers.");

    AST_RESET_MAIN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ12]
        (sel_bits == FSEL_RST_MAIN) |=> main_ctl.div_hold)
        else $error("Main counter reset did not hold the main dividers.");

    AST_RELEASE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ14]
        (sel_bits == FSEL_LOW && aux_mode == MODE_NORMAL && main_mode == MODE_NORMAL
         && st_q.pwr[LOOP_AUX] == PWR_ACTIVE && st_q.pwr[LOOP_MAIN] == PWR_ACTIVE)
        |=> (!aux_ctl.div_hold && !main_ctl.div_hold))
        else $error("Dividers not released in normal operation.");

    AST_MON_ROUTE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ15]
        (sel_bits == FSEL_AUX_FB) |=> (aux_ctl.power_off || main_ctl.power_off
        || multi_function_out == $past(st_q.sync[SY_MON+1])))
        else $error("Selected divider not routed to the output.");

    AST_MON_LOW: assert property (@(posedge clk_sys) disable iff (rst) // [RQ15]
        (sel_bits == 4'h0 || sel_bits > 4'h4) |=> !multi_function_out)
        else $error("Output not low without a monitor selected.");

    AST_LOOPS_APART: assert property (@(posedge clk_sys) disable iff (rst) // [RQ16]
        (st_q.pwr[LOOP_MAIN] == PWR_DOWN && st_q.pwr[LOOP_AUX] == PWR_ACTIVE
         && aux_mode == MODE_NORMAL) |=> (!aux_ctl.power_off && !aux_ctl.pump_float))
        else $error("Main powerdown disturbed the aux loop.");

    AST_PD_FLOAT: assert property (@(posedge clk_sys) disable iff (rst) // [RQ17]
        main_ctl.power_off |-> (main_ctl.pump_float && main_ctl.input_float))
        else $error("Powered-down loop did not float its pins.");

    AST_MAIN_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RQ18]
        (st_q.pwr[LOOP_MAIN] == PWR_DOWN) |-> main_ctl.div_hold)
        else $error("Powered-down main loop has dividers running.");

    AST_PULLUP: assert property (@(posedge clk_sys) disable iff (rst) // [RQ19]
        (st_q.pwr[LOOP_AUX] == PWR_DOWN && st_q.pwr[LOOP_MAIN] == PWR_DOWN)
        |-> (reference_pullup_en && osc_buffer_off))
        else $error("Reference input not pulled up with both loops down.");

    AST_WAKE_OSC: assert property (@(posedge clk_sys) disable iff (rst) // [RQ20]
        ($past(st_q.pwr[LOOP_MAIN]) == PWR_DOWN && st_q.pwr[LOOP_MAIN] == PWR_WAKE)
        |-> (!osc_buffer_off && !reference_pullup_en))
        else $error("Oscillator buffer not powered on wake.");

    AST_LATCH_IN_PD: assert property (@(posedge clk_sys) disable iff (rst) // [RQ21]
        (st_q.sync[SY_LATCH] && !st_q.latch_prev && aux_ctl.power_off && main_ctl.power_off)
        |=> (st_q.ctl[$past(word_addr)] == $past(word_data)))
        else $error("Word not latched during powerdown.");

    AST_SYNC_BUSY: assert property (@(posedge clk_sys) disable iff (rst) // [RQ22]
        (st_q.pwr[LOOP_AUX] == PWR_SYNC_END && st_q.sync[SY_BUSY+LOOP_AUX]
         && aux_mode == MODE_SYNC_PD) |=> !aux_ctl.power_off)
        else $error("Synchronous powerdown cut a pump pulse short.");

    AST_ACTIVE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ24]
        (main_mode == MODE_NORMAL && st_q.pwr[LOOP_MAIN] == PWR_ACTIVE)
        |=> (!main_ctl.pump_float && !main_ctl.power_off))
        else $error("Normal mode did not leave the loop running.");

endmodule : dssc_serial_control

`default_nettype wire

// [test/dssc_host_model.sv]
// Host model that shifts words into the serial control port.
`timescale 1ns/1ps
`default_nettype none
module dssc_host_model (
    // Pacing clock for the strobe
    input wire logic clk_sys,
    // Serial link
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // The link clock runs only inside a frame. Between frames the data line shows the
    // inverse of its last bit, so a stale level can never pass for a fresh one.
    task automatic send_word(input logic [21:0] w, input int junk);
        logic b;
        #3.1;
        for (int i = 0; i < junk + 22; i++) begin
            b = (i < junk) ? 1'($urandom) : w[21 - (i - junk)];
            ser_data = b;
            #6 ser_clk = 1'b1;
            #6 ser_clk = 1'b0;
        end
        ser_data = ~b;
        @(posedge clk_sys);
        latch_strobe <= 1'b1;
        repeat (4) @(posedge clk_sys);
        latch_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : send_word
endmodule : dssc_host_model
`default_nettype wire

// [test/dssc_serial_control_tb_top.sv]
// Self-checking bench for the dual synthesizer serial control block.
`timescale 1ns/1ps
`default_nettype none
module dssc_serial_control_tb_top
    import dssc_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic ser_clk;
    logic ser_data;
    logic latch_strobe;
    logic aux_busy;
    logic main_busy;
    logic [3:0] div_q;
    dssc_loop_s aux_ctl;
    dssc_loop_s main_ctl;
    logic osc_off;
    logic pull_en;
    logic mfo;
    logic sw_o;
    logic sw_oe;
    logic [21:0] wq [4];
    logic e;
    logic fast_cur;
    int n;
    int failures;
    int num_checks;

    dssc_host_model u_host (
        .clk_sys(clk_sys),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .latch_strobe(latch_strobe)
    );

    dssc_serial_control DUT (
        .clk_sys(clk_sys),
        .rst(rst),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .latch_strobe(latch_strobe),
        .aux_pump_busy(aux_busy),
        .main_pump_busy(main_busy),
        .aux_ref_div_out(div_q[0]),
        .aux_fb_div_out(div_q[1]),
        .main_ref_div_out(div_q[2]),
        .main_fb_div_out(div_q[3]),
        .aux_ctl(aux_ctl),
        .main_ctl(main_ctl),
        .osc_buffer_off(osc_off),
        .reference_pullup_en(pull_en),
        .multi_function_out(mfo),
        .rapid_switch_o(sw_o),
        .rapid_switch_oe(sw_oe)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : cyc

    // The bench copy of the four write-only registers mirrors every word sent.
    task automatic wr(input int a, input logic [2:0] top, input int junk);
        logic [21:0] w;
        w = {top, 17'($urandom), 2'(a)};
        if (a == 2) begin
            w[18] = fast_cur;
        end
        u_host.send_word(w, junk);
        wq[a] = w;
    endtask : wr

    task automatic flds(input int l);
        logic [21:0] r;
        logic [21:0] f;
        dssc_loop_s g;
        r = wq[2 * l];
        f = wq[2 * l + 1];
        g = (l == 1) ? main_ctl : aux_ctl;
        chk(32'(g.reference_divide_value), 32'(r[16:2]));
        chk(32'({g.detector_polarity, g.pump_current_sel}), 32'({r[17], r[18]}));
        chk(32'({g.binary_count_value, g.swallow_count_value, g.prescaler_sel}),
            32'({f[19:2], f[20]}));
    endtask : flds

    initial begin
        #500us;
        failures++;
        final_report();
    end

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        aux_busy = 1'b0;
        main_busy = 1'b0;
        div_q = 4'h0;
        fast_cur = 1'b0;
        void'($urandom(32'h8D96));
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        chk(32'(|{aux_ctl, main_ctl, osc_off, pull_en, mfo, sw_o, sw_oe}), 32'h0);
        wr(0, 3'h0, 0);
        wr(1, 3'h0, 3);
        wr(2, 3'h0, 0);
        wr(3, 3'h0, 25);
        flds(0);
        flds(1);
        for (int c = 0; c < 9; c++) begin
            wr(0, {c[0], c[2], 1'b0}, 0);
            fast_cur = (c == 5);
            wr(2, {c[1], c[3], 1'b0}, 0);
            for (int k = 0; k < 2; k++) begin
                @(posedge clk_sys);
                div_q <= (k == 1) ? ~div_q : 4'($urandom);
                cyc(5);
                e = (c >= 1 && c <= 4) ? div_q[c - 1] : 1'b0;
                chk(32'(mfo), 32'(e));
            end
            chk(32'({sw_oe, sw_o}), 32'({c == 5, 1'b0}));
            chk(32'(main_ctl.pump_current_sel), 32'(c == 5));
            chk(32'({aux_ctl.div_hold, main_ctl.div_hold}),
                32'({c == 6 || c == 8, c == 7 || c == 8}));
        end
        wr(0, 3'h0, 0);
        wr(2, 3'h0, 0);
        chk(32'({aux_ctl.div_hold, main_ctl.div_hold}), 32'h0);
        // Aux reference monitor stays selected while the loops go down.
        wr(0, 3'h4, 0);
        @(posedge clk_sys);
        div_q <= 4'hF;
        wr(2, 3'h1, 0);
        chk(32'({main_ctl.pump_float, main_ctl.power_off, mfo}), 32'h5);
        wr(3, 3'h4, 1);
        chk(32'({main_ctl.power_off, main_ctl.input_float, main_ctl.div_hold,
            aux_ctl.power_off}), 32'hE);
        chk(32'({mfo, osc_off}), 32'h0);
        wr(1, 3'h4, 0);
        cyc(20);
        chk(32'(aux_ctl.power_off), 32'h0);
        @(posedge clk_sys);
        {aux_busy, main_busy} <= 2'h3;
        cyc(4);
        {aux_busy, main_busy} <= 2'h0;
        n = 0;
        while (aux_ctl.power_off !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (n >= 20) begin
            failures++;
            final_report();
        end
        chk(32'({aux_ctl.power_off, aux_ctl.pump_float, aux_ctl.input_float,
            aux_ctl.div_hold, osc_off, pull_en}), 32'h3F);
        wr(2, 3'h1, 0);
        flds(1);
        wr(3, 3'h0, 0);
        chk(32'({main_ctl.power_off, main_ctl.div_hold, osc_off}), 32'h2);
        n = 0;
        while (main_ctl.div_hold === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(32'(n > int'(SETTLE_CYC) - 20 && n < int'(SETTLE_CYC)), 32'h1);
        final_report();
    end
endmodule : dssc_serial_control_tb_top
`default_nettype wire
